// [design/rxs_pkg.sv]
package rxs_pkg;

	// ==========================================================
	// Frame geometry
	localparam int          BITS_PER_FRAME   = 193;
	localparam logic [7:0]  LAST_BIT         = 8'hC0;
	localparam logic [3:0]  LAST_FRAME       = 4'hB;
	localparam logic [3:0]  SIG_FRAME_A      = 4'h5;
	localparam logic [3:0]  SIG_FRAME_B      = 4'hB;
	localparam logic [4:0]  NUM_CHANNELS     = 5'h18;
	// F bit of frames 1..12, frame 1 in bit 0
	localparam logic [11:0] FRAME_PATTERN    = 12'h3B1;
	localparam logic [3:0]  SYNC_MATCHES     = 4'hC;
	localparam logic [1:0]  SYNC_ERRORS      = 2'h2;
	localparam logic [8:0]  STORE_HALF       = 9'h0C1;
	localparam int          STORE_BITS       = 386;

	// ==========================================================
	// Timing
	localparam int          CLOCK_PERIOD_NS  = 5;
	localparam int          TX_CLOCK_LOSS_NS = 5000;
	localparam int          TX_LOSS_CYCLES   =
		(TX_CLOCK_LOSS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int          CLOCK_KHZ        = 200000;
	localparam int          EIGHT_MEG_KHZ    = 8192;
	localparam logic [15:0] NCO_STEP         =
		16'((EIGHT_MEG_KHZ * 65536) / CLOCK_KHZ);

	// ==========================================================
	// APB register map and fields
	localparam logic [11:0] REG_CONTROL      = 12'h000;
	localparam logic [11:0] REG_CHAN_BLOCK   = 12'h004;
	localparam logic [11:0] REG_STATUS       = 12'h008;
	localparam int          CTL_SYNC_SELECT  = 0;
	localparam int          CTL_DOUBLE_WIDE  = 1;
	localparam int          CTL_SYNC_DIR     = 2;
	localparam int          CTL_ES_ENABLE    = 3;
	localparam int          CTL_ALARM_SELECT = 4;
	localparam int          CTL_ZBTSI        = 5;
	localparam int          CTL_FREEZE       = 6;
	localparam logic [6:0]  CONTROL_RESET    = 7'h00;
	localparam logic [23:0] CHAN_BLOCK_RESET = 24'h000000;

	typedef enum {
		RXS_SEARCH,
		RXS_LOCKED
	} rxs_sync_state_t;

endpackage

// [design/rxs_slot_if.sv]
`timescale 1ns/10ps
interface rxs_slot_if;
	logic       adv;
	logic       slip;
	logic       align;
	logic       keep_frame;
	logic [7:0] bit_idx;
	logic [3:0] frame_idx;

	modport ctr (
		input  adv,
		input  slip,
		input  align,
		input  keep_frame,
		output bit_idx,
		output frame_idx
	);
	modport user (
		output adv,
		output slip,
		output align,
		output keep_frame,
		input  bit_idx,
		input  frame_idx
	);
endinterface

// [design/rxs_edge_sync.sv]
`timescale 1ns/10ps
module rxs_edge_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] prev_q;

	// ==========================================================
	// Two-stage synchroniser, edges read only from the second stage
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise  = sync_q & ~prev_q;
	assign fall  = ~sync_q & prev_q;
endmodule

// [design/rxs_slot_counter.sv]
`timescale 1ns/10ps
module rxs_slot_counter (
	input  wire logic clk,
	input  wire logic rst_n,
	rxs_slot_if.ctr   slot
);
	logic [7:0] bit_q;
	logic [3:0] frame_q;

	// ==========================================================
	// Bit position within frame, frame within superframe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bit_q   <= 8'h00;
			frame_q <= 4'h0;
		end else if (slot.align) begin
			bit_q   <= 8'h00;
			frame_q <= slot.keep_frame ? frame_q : 4'h0;
		end else if (slot.adv && !slot.slip) begin
			if (bit_q == rxs_pkg::LAST_BIT) begin
				bit_q   <= 8'h00;
				frame_q <= (frame_q == rxs_pkg::LAST_FRAME) ? 4'h0
					: frame_q + 4'h1;
			end else begin
				bit_q <= bit_q + 8'h01;
			end
		end
	end

	assign slot.bit_idx   = bit_q;
	assign slot.frame_idx = frame_q;
endmodule

// [design/rxs_receive_timing.sv]
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
// Operation
// [R1] Link data changes one line clock before each frame starts; here only after odd frame_idx, or frame_idx[1:0] of 3 in ZBTSI.
// [R2] Link clock runs at 4 kHz, or 2 kHz in ZBTSI mode.
// [R3] Channel clock is high during each channel's last bit, 192 kHz.
// [R4] Channel clock and block follow line or system timing per store.
// [R5] Channel block level per channel comes from a 24-bit register.
// [R6] Serial data changes on line edges, or system edges with store.
// [R7] Signaling bits go out in PCM slot format on the active timing.
// [R8] Sync pulse one line clock wide marks frames or multiframes.
// [R9] Double-wide option stretches frame sync to two bits on signaling frames.
// [R10] With store and input direction, the sync pin takes an outside pulse.
// [R11] Frame pulse one line clock wide marks every frame boundary.
// [R12] Multiframe pulse follows system timing with store, line otherwise.
// [R13] Receive data output changes on each rising line clock edge.
// [R14] Outside logic supplies the system clock, held low if unused.
// [R15] Alarm shows sync search or 5 us without transmit clock edges.
// [R16] Carrier loss output follows the line interface detector.
// [R17] Freeze output is high while signaling is frozen, auto or manual.
// [R18] An 8.192 MHz clock is produced, phased to the line clock.
// [R19] Line interface data outputs change on its recovered clock rise.
// [R20] Framer samples its inputs on the falling receive clock edge.
// [R21] Framer steps one bit per 1.544 MHz line clock period.
// [R22] Strap high connects framer inputs to the line interface outputs.
// [R23] Strap high means outside framer pins are unused and tied low.
// [R24] A frame is 193 bits: 24 eight-bit channels and one F bit.
// [R25] Frames six and twelve of a superframe are signaling frames.
module rxs_receive_timing (
	input  wire logic        CLOCK,
	input  wire logic        RST_N,
	input  wire logic [11:0] PADDR,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        LI_CLOCK_IN,
	input  wire logic        LI_POSITIVE_IN,
	input  wire logic        LI_NEGATIVE_IN,
	input  wire logic        LI_CARRIER_LOSS_IN,
	input  wire logic        FRAMER_POSITIVE_DATA_IN,
	input  wire logic        FRAMER_NEGATIVE_DATA_IN,
	input  wire logic        FRAMER_CLOCK_IN,
	input  wire logic        LINE_INTERFACE_CONNECT_STRAP,
	input  wire logic        RECV_SYSTEM_CLOCK,
	input  wire logic        TRANSMIT_LINE_CLOCK,
	input  wire logic        RECV_SYNC_PIN_I,
	output logic             RECV_SYNC_PIN_O,
	output logic             RECV_SYNC_PIN_OE,
	output logic             LI_POSITIVE_DATA_OUT,
	output logic             LI_NEGATIVE_DATA_OUT,
	output logic             LI_RECOVERED_CLOCK_OUT,
	output logic             RECV_LINE_CLOCK_OUT,
	output logic             RECV_DATA_OUT,
	output logic             RECV_SERIAL_OUT,
	output logic             RECV_SIGNALING_OUT,
	output logic             RECV_CHANNEL_CLOCK,
	output logic             RECV_CHANNEL_BLOCK,
	output logic             RECV_LINK_DATA,
	output logic             RECV_LINK_CLOCK,
	output logic             RECV_FRAME_PULSE,
	output logic             RECV_MULTIFRAME_PULSE,
	output logic             SYNC_LOSS_OR_TX_CLOCK_LOSS,
	output logic             CARRIER_LOSS_OUT,
	output logic             SIGNALING_FREEZE_OUT,
	output logic             EIGHT_MEG_CLOCK_OUT
);
	// ==========================================================
	// Pin synchronisers
	logic [10:0] pin_raw;
	logic [10:0] pin_lvl;
	logic [10:0] pin_rise;
	logic [10:0] pin_fall;

	assign pin_raw = {LI_CLOCK_IN, LI_POSITIVE_IN, LI_NEGATIVE_IN,
		LI_CARRIER_LOSS_IN, FRAMER_POSITIVE_DATA_IN,
		FRAMER_NEGATIVE_DATA_IN, FRAMER_CLOCK_IN,
		LINE_INTERFACE_CONNECT_STRAP, RECV_SYSTEM_CLOCK,
		TRANSMIT_LINE_CLOCK, RECV_SYNC_PIN_I};

	rxs_edge_sync #(.WIDTH(11)) u_sync (
		.clk   (CLOCK),
		.rst_n (RST_N),
		.pin   (pin_raw),
		.level (pin_lvl),
		.rise  (pin_rise),
		.fall  (pin_fall)
	);

	logic li_clk_rise;
	logic li_pos;
	logic li_neg;
	logic carrier_loss;
	logic strap;
	logic sys_rise;
	logic tx_edge;
	logic ext_sync_rise;

	assign li_clk_rise   = pin_rise[10];
	assign li_pos        = pin_lvl[9];
	assign li_neg        = pin_lvl[8];
	assign carrier_loss  = pin_lvl[7];
	assign strap         = pin_lvl[3];
	assign sys_rise      = pin_rise[2];
	assign tx_edge       = pin_rise[1] | pin_fall[1];
	assign ext_sync_rise = pin_rise[0];

	// ==========================================================
	// APB registers
	logic [6:0]  control_q;
	logic [23:0] chan_block_q;
	logic        in_sync;
	logic        tx_clock_lost;
	logic        frozen;
	logic        apb_access;

	assign apb_access = PSEL && PENABLE && !PREADY;

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			control_q    <= rxs_pkg::CONTROL_RESET;
			chan_block_q <= rxs_pkg::CHAN_BLOCK_RESET;
		end else if (apb_access && PWRITE) begin
			if (PADDR == rxs_pkg::REG_CONTROL)
				control_q <= PWDATA[6:0];
			if (PADDR == rxs_pkg::REG_CHAN_BLOCK)
				chan_block_q <= PWDATA[23:0];
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h00000000;
		end else begin
			PREADY  <= apb_access;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h00000000;
			if (apb_access) begin
				unique case (PADDR)
					rxs_pkg::REG_CONTROL:
						PRDATA <= {25'h0000000, control_q};
					rxs_pkg::REG_CHAN_BLOCK:
						PRDATA <= {8'h00, chan_block_q};
					rxs_pkg::REG_STATUS:
						PRDATA <= {28'h0000000, frozen, tx_clock_lost,
							carrier_loss, in_sync};
					default:
						PSLVERR <= 1'b1;
				endcase
			end
		end
	end

	logic sync_select;
	logic double_wide;
	logic es_enable;
	logic sync_input;

	assign sync_select = control_q[rxs_pkg::CTL_SYNC_SELECT];
	assign double_wide = control_q[rxs_pkg::CTL_DOUBLE_WIDE];
	assign es_enable   = control_q[rxs_pkg::CTL_ES_ENABLE];
	assign sync_input  = es_enable && control_q[rxs_pkg::CTL_SYNC_DIR];

	// ==========================================================
	// Line interface outputs and framer input selection
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			LI_POSITIVE_DATA_OUT   <= 1'b0;
			LI_NEGATIVE_DATA_OUT   <= 1'b0;
			LI_RECOVERED_CLOCK_OUT <= 1'b0;
		end else begin
			LI_RECOVERED_CLOCK_OUT <= pin_lvl[10];
			// [R19] Data on recovered rise
			if (li_clk_rise) begin
				LI_POSITIVE_DATA_OUT <= li_pos;
				LI_NEGATIVE_DATA_OUT <= li_neg;
			end
		end
	end

	// [R22] Strap picks internal path
	// [R23] Outside pins ignored then
	logic fr_clk_rise;
	logic fr_clk_fall;
	logic fr_clk_lvl;
	logic fr_bit;

	assign fr_clk_rise = strap ? pin_rise[10] : pin_rise[4];
	assign fr_clk_fall = strap ? pin_fall[10] : pin_fall[4];
	assign fr_clk_lvl  = strap ? pin_lvl[10]  : pin_lvl[4];
	// [R20] Pos and neg ORed, NRZ
	assign fr_bit = strap ? (LI_POSITIVE_DATA_OUT | LI_NEGATIVE_DATA_OUT)
		: (pin_lvl[6] | pin_lvl[5]);

	// ==========================================================
	// Line and system slot counters
	rxs_slot_if line_slot ();
	rxs_slot_if sys_slot ();

	rxs_slot_counter u_line_ctr (
		.clk   (CLOCK),
		.rst_n (RST_N),
		.slot  (line_slot.ctr)
	);
	rxs_slot_counter u_sys_ctr (
		.clk   (CLOCK),
		.rst_n (RST_N),
		.slot  (sys_slot.ctr)
	);

	logic slip_q;

	// [R21] One bit per line clock
	assign line_slot.adv        = fr_clk_rise;
	assign line_slot.slip       = slip_q;
	assign line_slot.align      = 1'b0;
	assign line_slot.keep_frame = 1'b0;
	assign sys_slot.adv         = sys_rise;
	assign sys_slot.slip        = 1'b0;
	// [R10] Outside pulse realigns system timing
	assign sys_slot.align       = sync_input && ext_sync_rise;
	assign sys_slot.keep_frame  = !sync_select;

	function automatic logic [4:0] chan_of(input logic [7:0] b);
		logic [7:0] p;
		p = b - 8'h01;
		return p[7:3];
	endfunction

	function automatic logic is_lsb(input logic [7:0] b);
		logic [7:0] p;
		p = b - 8'h01;
		return (b != 8'h00) && (p[2:0] == 3'h7);
	endfunction

	// ==========================================================
	// Frame synchroniser on the F bit
	rxs_pkg::rxs_sync_state_t state_q;
	logic [3:0] match_q;
	logic [1:0] err_q;
	logic       f_ok;
	logic       f_time;
	logic       rx_bit_q;

	// [R24] F bit at position 0 of 193
	assign f_time  = fr_clk_fall && (line_slot.bit_idx == 8'h00);
	assign f_ok    = fr_bit == rxs_pkg::FRAME_PATTERN[line_slot.frame_idx];
	assign in_sync = state_q == rxs_pkg::RXS_LOCKED;

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			state_q <= rxs_pkg::RXS_SEARCH;
			match_q <= 4'h0;
			err_q   <= 2'h0;
			slip_q  <= 1'b0;
		end else begin
			if (fr_clk_rise)
				slip_q <= 1'b0;
			if (f_time) begin
				unique case (state_q)
					rxs_pkg::RXS_SEARCH: begin
						match_q <= f_ok ? match_q + 4'h1 : 4'h0;
						slip_q  <= !f_ok;
						if (f_ok && match_q == rxs_pkg::SYNC_MATCHES - 4'h1)
							state_q <= rxs_pkg::RXS_LOCKED;
					end
					rxs_pkg::RXS_LOCKED: begin
						err_q <= f_ok ? 2'h0 : err_q + 2'h1;
						match_q <= 4'h0;
						if (!f_ok && err_q == rxs_pkg::SYNC_ERRORS - 2'h1) begin
							state_q <= rxs_pkg::RXS_SEARCH;
							err_q   <= 2'h0;
						end
					end
				endcase
			end
		end
	end

	// [R20] Sample on falling edge
	always_ff @(posedge CLOCK) begin
		if (!RST_N)
			rx_bit_q <= 1'b0;
		else if (fr_clk_fall)
			rx_bit_q <= fr_bit;
	end

	// ==========================================================
	// Signaling capture and freeze
	logic [23:0] sig_a_q;
	logic [23:0] sig_b_q;
	logic [4:0]  line_chan;

	assign line_chan = chan_of(line_slot.bit_idx);
	// [R17] Freeze on loss or by software
	assign frozen = control_q[rxs_pkg::CTL_FREEZE] || !in_sync
		|| carrier_loss;

	// [R25] Frames six and twelve carry signaling
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			sig_a_q <= 24'h000000;
			sig_b_q <= 24'h000000;
		end else if (fr_clk_fall && !frozen
			&& is_lsb(line_slot.bit_idx)) begin
			if (line_slot.frame_idx == rxs_pkg::SIG_FRAME_A)
				sig_a_q[line_chan] <= fr_bit;
			if (line_slot.frame_idx == rxs_pkg::SIG_FRAME_B)
				sig_b_q[line_chan] <= fr_bit;
		end
	end

	// ==========================================================
	// Elastic store, two frames deep; no slip control, so the
	// system clock must track the line rate on average
	logic       store_q [rxs_pkg::STORE_BITS];
	logic       wr_half_q;
	logic       rd_half_q;
	logic [8:0] wr_addr;
	logic [8:0] rd_addr;

	assign wr_addr = (wr_half_q ? rxs_pkg::STORE_HALF : 9'h000)
		+ {1'b0, line_slot.bit_idx};
	assign rd_addr = (rd_half_q ? rxs_pkg::STORE_HALF : 9'h000)
		+ {1'b0, sys_slot.bit_idx};

	always_ff @(posedge CLOCK) begin
		if (fr_clk_fall)
			store_q[wr_addr] <= fr_bit;
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			wr_half_q <= 1'b0;
			rd_half_q <= 1'b1;
		end else begin
			if (fr_clk_rise && line_slot.bit_idx == rxs_pkg::LAST_BIT)
				wr_half_q <= !wr_half_q;
			if (sys_rise && sys_slot.bit_idx == rxs_pkg::LAST_BIT)
				rd_half_q <= !rd_half_q;
		end
	end

	// ==========================================================
	// Timing-selected and line-timed outputs
	logic [7:0] act_bit;
	logic [3:0] act_frame;
	logic [4:0] act_chan;
	logic [7:0] act_pos;
	logic       act_step;
	logic       line_sig_frame;

	// [R4] Store enable picks the timing
	assign act_bit   = es_enable ? sys_slot.bit_idx : line_slot.bit_idx;
	assign act_frame = es_enable ? sys_slot.frame_idx : line_slot.frame_idx;
	assign act_step  = es_enable ? sys_rise : fr_clk_rise;
	assign act_chan  = chan_of(act_bit);
	assign act_pos   = act_bit - 8'h01;
	assign line_sig_frame = line_slot.frame_idx == rxs_pkg::SIG_FRAME_A
		|| line_slot.frame_idx == rxs_pkg::SIG_FRAME_B;

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			RECV_CHANNEL_CLOCK <= 1'b0;
			RECV_CHANNEL_BLOCK <= 1'b0;
			RECV_SERIAL_OUT    <= 1'b0;
			RECV_SIGNALING_OUT <= 1'b0;
		end else if (act_step) begin
			// [R3] High on channel LSB
			RECV_CHANNEL_CLOCK <= is_lsb(act_bit);
			// [R5] Per-channel block level
			RECV_CHANNEL_BLOCK <= (act_bit != 8'h00)
				&& (act_chan < rxs_pkg::NUM_CHANNELS)
				&& chan_block_q[act_chan];
			// [R6] Serial data per timing
			RECV_SERIAL_OUT <= es_enable ? store_q[rd_addr] : rx_bit_q;
			// [R7] ABAB in the low nibble
			RECV_SIGNALING_OUT <= (act_bit != 8'h00) && act_pos[2]
				&& (act_pos[0] ? sig_b_q[act_chan] : sig_a_q[act_chan]);
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			RECV_DATA_OUT       <= 1'b0;
			RECV_LINE_CLOCK_OUT <= 1'b0;
			RECV_FRAME_PULSE    <= 1'b0;
			RECV_SYNC_PIN_O     <= 1'b0;
			RECV_SYNC_PIN_OE    <= 1'b0;
		end else begin
			RECV_LINE_CLOCK_OUT <= fr_clk_lvl;
			RECV_SYNC_PIN_OE    <= !sync_input;
			if (fr_clk_rise) begin
				// [R13] Framer data on line rise
				RECV_DATA_OUT <= rx_bit_q;
				// [R11] One bit wide per frame
				RECV_FRAME_PULSE <= line_slot.bit_idx == 8'h00;
				// [R8] Frame or multiframe mark
				// [R9] Second bit on signaling frames
				if (sync_select)
					RECV_SYNC_PIN_O <= line_slot.bit_idx == 8'h00
						&& line_slot.frame_idx == 4'h0;
				else
					RECV_SYNC_PIN_O <= line_slot.bit_idx == 8'h00
						|| (double_wide && line_sig_frame
						&& line_slot.bit_idx == 8'h01);
			end
		end
	end

	// [R12] Multiframe mark on active timing
	always_ff @(posedge CLOCK) begin
		if (!RST_N)
			RECV_MULTIFRAME_PULSE <= 1'b0;
		else if (act_step)
			RECV_MULTIFRAME_PULSE <= act_bit == 8'h00
				&& act_frame == 4'h0;
	end

	// ==========================================================
	// Link data and clock
	logic link_frame;

	assign link_frame = control_q[rxs_pkg::CTL_ZBTSI]
		? (line_slot.frame_idx[1:0] == 2'h3) : line_slot.frame_idx[0];

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			RECV_LINK_DATA  <= 1'b0;
			RECV_LINK_CLOCK <= 1'b0;
		end else if (fr_clk_rise) begin
			// [R2] 4 or 2 kHz from frame count
			RECV_LINK_CLOCK <= control_q[rxs_pkg::CTL_ZBTSI]
				? line_slot.frame_idx[1] : line_slot.frame_idx[0];
			// [R1] Update on last bit of frame
			if (line_slot.bit_idx == rxs_pkg::LAST_BIT && link_frame)
				RECV_LINK_DATA <= store_q[wr_half_q ? 9'h000
					: rxs_pkg::STORE_HALF];
		end
	end

	// ==========================================================
	// Alarms and the 8.192 MHz clock
	logic [9:0]  tx_idle_q;
	logic [15:0] nco_q;

	assign tx_clock_lost = tx_idle_q == 10'(rxs_pkg::TX_LOSS_CYCLES);

	always_ff @(posedge CLOCK) begin
		if (!RST_N)
			tx_idle_q <= 10'h000;
		else if (tx_edge)
			tx_idle_q <= 10'h000;
		else if (!tx_clock_lost)
			tx_idle_q <= tx_idle_q + 10'h001;
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			SYNC_LOSS_OR_TX_CLOCK_LOSS <= 1'b0;
			CARRIER_LOSS_OUT           <= 1'b0;
			SIGNALING_FREEZE_OUT       <= 1'b0;
		end else begin
			// [R15] Search or transmit clock idle
			SYNC_LOSS_OR_TX_CLOCK_LOSS <=
				control_q[rxs_pkg::CTL_ALARM_SELECT] ? tx_clock_lost
				: !in_sync;
			// [R16] Follows carrier detector
			CARRIER_LOSS_OUT <= carrier_loss;
			// [R17] Frozen flag out
			SIGNALING_FREEZE_OUT <= frozen;
		end
	end

	// [R18] Phase restarts at each frame
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			nco_q               <= 16'h0000;
			EIGHT_MEG_CLOCK_OUT <= 1'b0;
		end else begin
			if (fr_clk_rise && line_slot.bit_idx == 8'h00)
				nco_q <= 16'h0000;
			else
				nco_q <= nco_q + rxs_pkg::NCO_STEP;
			EIGHT_MEG_CLOCK_OUT <= nco_q[15];
		end
	end
endmodule

// [verif/rxs_asserts.sv]
`timescale 1ns/10ps
module rxs_asserts (
	input wire logic        CLOCK,
	input wire logic        RST_N,
	input wire logic [11:0] PADDR,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        LI_CLOCK_IN,
	input wire logic        LI_CARRIER_LOSS_IN,
	input wire logic        CARRIER_LOSS_OUT,
	input wire logic        SIGNALING_FREEZE_OUT,
	input wire logic        RECV_FRAME_PULSE,
	input wire logic        RECV_CHANNEL_CLOCK,
	input wire logic        RECV_DATA_OUT,
	input wire logic        SYNC_LOSS_OR_TX_CLOCK_LOSS,
	input wire logic        LI_POSITIVE_DATA_OUT,
	input wire logic        LI_RECOVERED_CLOCK_OUT
);
	// ========================================
	// Bus and timing checks
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N);

	sequence s_access;
		PSEL && PENABLE && !PREADY;
	endsequence

	a_apb_wait_state: assert property (s_access |=> PREADY)
		else $error("ready missing after one wait state");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready held longer than one cycle");
	a_unmapped_err: assert property (PREADY |->
		PSLVERR == !(PADDR inside {12'h000, 12'h004, 12'h008}))
		else $error("error response does not match address map");
	a_carrier_set: assert property (
		LI_CARRIER_LOSS_IN [*8] |-> CARRIER_LOSS_OUT)
		else $error("carrier loss not shown");
	a_carrier_clear: assert property (
		!LI_CARRIER_LOSS_IN [*8] |-> !CARRIER_LOSS_OUT)
		else $error("carrier loss shown without cause");
	a_freeze_on_loss: assert property (
		CARRIER_LOSS_OUT |-> ##[0:4] SIGNALING_FREEZE_OUT)
		else $error("freeze not raised on carrier loss");
	// Search slips hold the bit count, so widths hold only once locked
	a_frame_width: assert property (
		$rose(RECV_FRAME_PULSE) && !SYNC_LOSS_OR_TX_CLOCK_LOSS
		|-> ##[20:30] $fell(RECV_FRAME_PULSE))
		else $error("frame pulse not one line period wide");
	a_chclk_width: assert property (
		$rose(RECV_CHANNEL_CLOCK) |-> ##[20:30] $fell(RECV_CHANNEL_CLOCK))
		else $error("channel clock high time wrong");
	a_chclk_period: assert property (
		$rose(RECV_CHANNEL_CLOCK) && !SYNC_LOSS_OR_TX_CLOCK_LOSS
		|=> ##[189:234] $rose(RECV_CHANNEL_CLOCK))
		else $error("channel clock period wrong");
	a_rdata_rise: assert property (
		$changed(RECV_DATA_OUT) |->
		$past(LI_CLOCK_IN, 2) && !$past(LI_CLOCK_IN, 8))
		else $error("receive data moved off a line clock rise");
	a_li_data_rise: assert property (
		$changed(LI_POSITIVE_DATA_OUT) |-> LI_RECOVERED_CLOCK_OUT)
		else $error("line data moved off a recovered clock rise");
endmodule

bind rxs_receive_timing rxs_asserts u_asserts (.*);

// [verif/rxs_line_src.sv]
`timescale 1ns/10ps
module rxs_line_src (
	output logic line_clk,
	output logic pos,
	output logic neg,
	output logic sys_clk
);
	int   bit_n   = 0;
	int   frame_n = 0;
	logic mark;
	logic alt     = 1'h0;

	assign sys_clk = 1'h0;

	// ========================================
	// Free-running line, phase kept off the core clock edges
	initial begin
		line_clk = 1'h0;
		pos = 1'h0;
		neg = 1'h0;
		#1.3;
		forever begin
			#62.5;
			line_clk = 1'h1;
			// F bit then 192 payload bits
			mark = (bit_n == 0) ? rxs_pkg::FRAME_PATTERN[frame_n] : bit_n[1];
			pos = mark & !alt;
			neg = mark & alt;
			alt = alt ^ mark;
			bit_n = (bit_n == 192) ? 0 : bit_n + 1;
			if (bit_n == 0)
				frame_n = (frame_n + 1) % 12;
			#62.5;
			line_clk = 1'h0;
		end
	end
endmodule

// [verif/testbench.sv]
`timescale 1ns/10ps
module testbench;
	localparam int LINE_CYC = 25;
	logic CLOCK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic LI_CLOCK_IN, LI_POSITIVE_IN, LI_NEGATIVE_IN, LI_CARRIER_LOSS_IN;
	logic FRAMER_POSITIVE_DATA_IN, FRAMER_NEGATIVE_DATA_IN, FRAMER_CLOCK_IN;
	logic LINE_INTERFACE_CONNECT_STRAP, RECV_SYSTEM_CLOCK;
	logic TRANSMIT_LINE_CLOCK, RECV_SYNC_PIN_I, RECV_SYNC_PIN_O;
	logic RECV_SYNC_PIN_OE, LI_POSITIVE_DATA_OUT, LI_NEGATIVE_DATA_OUT;
	logic LI_RECOVERED_CLOCK_OUT, RECV_LINE_CLOCK_OUT, RECV_DATA_OUT;
	logic RECV_SERIAL_OUT, RECV_SIGNALING_OUT, RECV_CHANNEL_CLOCK;
	logic RECV_CHANNEL_BLOCK, RECV_LINK_DATA, RECV_LINK_CLOCK;
	logic RECV_FRAME_PULSE, RECV_MULTIFRAME_PULSE, SYNC_LOSS_OR_TX_CLOCK_LOSS;
	logic CARRIER_LOSS_OUT, SIGNALING_FREEZE_OUT, EIGHT_MEG_CLOCK_OUT;
	logic tx_run = 1'h1;
	int   failures = 0, num_checks = 0, fp = 0, cc = 0, cb = 0, sp = 0;
	int   sd = 0;

	assign RECV_SYNC_PIN_I = RECV_SYNC_PIN_OE ? RECV_SYNC_PIN_O : 1'h0;
	rxs_receive_timing dut (.*);
	rxs_line_src far_end (
		.line_clk (LI_CLOCK_IN),
		.pos      (LI_POSITIVE_IN),
		.neg      (LI_NEGATIVE_IN),
		.sys_clk  (RECV_SYSTEM_CLOCK)
	);

	initial begin
		CLOCK = 1'h0;
		forever #2.5 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK) begin
		if (!RST_N)
			TRANSMIT_LINE_CLOCK <= 1'h0;
		else if (tx_run)
			TRANSMIT_LINE_CLOCK <= ~TRANSMIT_LINE_CLOCK;
	end

	// ========================================
	// Bus access and comparison
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		@(posedge CLOCK);
		PSEL    <= 1'h1;
		PWRITE  <= w;
		PADDR   <= a;
		PWDATA  <= d;
		@(posedge CLOCK);
		PENABLE <= 1'h1;
		do
			@(posedge CLOCK);
		while (PREADY !== 1'h1);
		rd      = PRDATA;
		err     = PSLVERR;
		PSEL    <= 1'h0;
		PENABLE <= 1'h0;
	endtask
	task automatic chk(input string s, input logic [31:0] e,
			input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
			input string s);
		apb(1'h0, a, 32'h0);
		chk(s, e, rd);
	endtask
	task automatic end_of_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		#500000;
		failures++;
		end_of_test();
	end

	// ========================================
	// Tests
	initial begin
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
		// strap high, framer pins tied low
		{FRAMER_POSITIVE_DATA_IN, FRAMER_NEGATIVE_DATA_IN} = 2'h0;
		FRAMER_CLOCK_IN = 1'h0;
		LINE_INTERFACE_CONNECT_STRAP = 1'h1;
		LI_CARRIER_LOSS_IN = 1'h0;
		RST_N = 1'h0;
		repeat (6) @(posedge CLOCK);
		RST_N <= 1'h1;
		rdchk(12'h000, 32'h0, "control");
		rdchk(12'h004, 32'h0, "chan_block");
		rdchk(12'h00C, 32'h0, "unmapped");
		chk("slverr", 32'h1, err);
		chk("search_alarm", 32'h1, SYNC_LOSS_OR_TX_CLOCK_LOSS);
		chk("auto_freeze", 32'h1, SIGNALING_FREEZE_OUT);
		apb(1'h1, 12'h004, 32'hFFFFFFFF);
		rdchk(12'h004, 32'h00FFFFFF, "chan_block");
		apb(1'h1, 12'h000, 32'h0000000C);
		rdchk(12'h000, 32'h0000000C, "control");
		chk("sync_pin_input", 32'h0, RECV_SYNC_PIN_OE);
		apb(1'h1, 12'h000, 32'h0);
		rdchk(12'h000, 32'h0, "control");
		chk("sync_pin_output", 32'h1, RECV_SYNC_PIN_OE);
		do
			apb(1'h0, 12'h008, 32'h0);
		while (rd[0] !== 1'h1);
		chk("locked_alarm", 32'h0, SYNC_LOSS_OR_TX_CLOCK_LOSS);
		chk("locked_freeze", 32'h0, SIGNALING_FREEZE_OUT);
		apb(1'h1, 12'h004, 32'h00000001);
		@(posedge RECV_FRAME_PULSE);
		repeat (rxs_pkg::BITS_PER_FRAME * LINE_CYC) begin
			@(posedge CLOCK);
			fp += int'(RECV_FRAME_PULSE);
			cc += int'(RECV_CHANNEL_CLOCK);
			cb += int'(RECV_CHANNEL_BLOCK);
			sp += int'(RECV_SYNC_PIN_O);
			sd += int'(RECV_SERIAL_OUT !== RECV_DATA_OUT);
		end
		@(posedge CLOCK);
		chk("frame_next", 32'h1, RECV_FRAME_PULSE);
		chk("frame_high", LINE_CYC, fp);
		chk("chan_clock", 24 * LINE_CYC, cc);
		chk("chan_block", 8 * LINE_CYC, cb);
		chk("sync_pulse", LINE_CYC, sp);
		chk("serial_vs_data", 32'h0, sd);
		apb(1'h1, 12'h000, 32'h00000010);
		tx_run <= 1'h0;
		repeat (900) @(posedge CLOCK);
		chk("tx_loss_early", 32'h0, SYNC_LOSS_OR_TX_CLOCK_LOSS);
		repeat (200) @(posedge CLOCK);
		chk("tx_loss", 32'h1, SYNC_LOSS_OR_TX_CLOCK_LOSS);
		tx_run <= 1'h1;
		repeat (20) @(posedge CLOCK);
		chk("tx_back", 32'h0, SYNC_LOSS_OR_TX_CLOCK_LOSS);
		apb(1'h1, 12'h000, 32'h00000040);
		rdchk(12'h008, 32'h00000009, "status");
		chk("manual_freeze", 32'h1, SIGNALING_FREEZE_OUT);
		LI_CARRIER_LOSS_IN <= 1'h1;
		repeat (10) @(posedge CLOCK);
		chk("carrier_loss", 32'h1, CARRIER_LOSS_OUT);
		end_of_test();
	end
endmodule
